// ---- verilog/esc_pkg.sv ----
// Constants and types shared by the exception status capture block.
// Bit positions are little-endian: position p holds the documented bit 31-p.
package esc_pkg;
  localparam int SEL_W = 14;
  localparam logic [13:0] SEL_STATUS = 14'h0005;
  localparam logic [13:0] SEL_FLOAT = 14'h0007;
  localparam logic [13:0] SEL_BRANCH = 14'h000B;
  localparam logic [13:0] SEL_DATA = 14'h000D;

  typedef enum logic [4:0] {
    CAUSE_LINK = 5'h00,
    CAUSE_UNALIGNED = 5'h01,
    CAUSE_ILLEGAL = 5'h02,
    CAUSE_IBUS = 5'h03,
    CAUSE_DBUS = 5'h04,
    CAUSE_DIV_ZERO = 5'h05,
    CAUSE_FLOAT = 5'h06,
    CAUSE_PRIV = 5'h07,
    CAUSE_DSTORAGE = 5'h10,
    CAUSE_ISTORAGE = 5'h11,
    CAUSE_DTLB = 5'h12,
    CAUSE_ITLB = 5'h13
  } esc_cause_t;

  // Detail field: index 6 is bit 20, index 0 is bit 26
  localparam int DET_W = 7;
  localparam int DET_TOP_BIT = 6;
  localparam int DET_STORE_BIT = 5;
  localparam int LINK_IDX_W = 4;

  // Status word layout
  localparam int CAUSE_W = 5;
  localparam int STAT_CAUSE_LSB = 0;
  localparam int STAT_DET_LSB = 5;
  localparam int STAT_DS_POS = 12;

  // Float status flags
  localparam int FLT_W = 5;
  localparam int FLT_INVALID = 4;
  localparam int FLT_DIV_ZERO = 3;
  localparam int FLT_OVERFLOW = 2;
  localparam int FLT_UNDERFLOW = 1;
  localparam int FLT_DENORMAL = 0;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [4:0] CAUSE_RESET = 5'h00;
  localparam logic [6:0] DET_RESET = 7'h00;
  localparam logic [4:0] FLT_RESET = 5'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ---- verilog/esc_capture.sv ----
// Load-enabled capture register used for the branch target and link data words.
// Assumes load and d come from logic on the same clock.
`timescale 1ns/1ps
module esc_capture #(
  parameter int WIDTH = 32,
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RESET_VAL[WIDTH-1:0];
    end else if (load) begin
      q <= d;
    end
  end
endmodule

// ---- verilog/esc_detail_enc.sv ----
// Builds the cause-specific detail field from the qualifiers of a faulting access.
// Assumes the qualifiers are valid in the cycle the exception is entered.
`timescale 1ns/1ps
module esc_detail_enc (
  input wire esc_pkg::esc_cause_t cause,
  input wire logic word_access,
  input wire logic store_access,
  input wire logic zone_protect,
  input wire logic [3:0] link_index,
  output logic [6:0] detail
);
  wire is_link = (cause == esc_pkg::CAUSE_LINK);
  wire is_unal = (cause == esc_pkg::CAUSE_UNALIGNED);
  wire is_dsto = (cause == esc_pkg::CAUSE_DSTORAGE);
  wire is_isto = (cause == esc_pkg::CAUSE_ISTORAGE);
  wire is_dtlb = (cause == esc_pkg::CAUSE_DTLB);
  // Every qualifier is gated by its cause so unrelated inputs never leak in
  wire top_bit = (is_unal & word_access) | ((is_dsto | is_isto) & zone_protect);
  wire store_bit = (is_unal | is_dsto | is_dtlb) & store_access;
  wire [3:0] link_bits = is_link ? link_index : 4'h0;
  assign detail = {top_bit, store_bit, 1'b0, link_bits};
endmodule

// ---- verilog/esc_top.sv ----
// Exception status, branch target, float status and link data capture for a core.
// Assumes all inputs come from core pipeline logic on SYS_CLK; selector reads are
// answered one cycle after the move-from-special strobe.
`timescale 1ns/1ps
module esc_top #(
  parameter bit EXC_SUPPORT = 1'b1,
  parameter int LINK_COUNT = 1,
  parameter bit LINK_EXC_OPT = 1'b1
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic MOVE_FROM_SPECIAL,
  input wire logic MOVE_TO_SPECIAL,
  input wire logic [13:0] SPECIAL_REG_SELECTOR,
  input wire logic [31:0] SPECIAL_WRITE_DATA,
  output logic [31:0] SPECIAL_READ_DATA,
  output logic SPECIAL_READ_VALID,
  input wire logic EXC_ENTER,
  input wire logic [4:0] EXC_CAUSE,
  input wire logic EXC_DELAY_SLOT,
  input wire logic EXC_WORD_ACCESS,
  input wire logic EXC_STORE_ACCESS,
  input wire logic EXC_ZONE_PROTECT,
  input wire logic [3:0] EXC_LINK_INDEX,
  input wire logic [31:0] EXC_LINK_DATA,
  input wire logic EXC_RETURN,
  input wire logic BRANCH_IN_DELAY_SLOT,
  input wire logic [31:0] BRANCH_TARGET,
  input wire logic [4:0] FLOAT_FLAG_SET,
  output logic EXCEPTION_ACTIVE,
  output logic DELAY_SLOT_FLAG
);
  localparam bit HAS_BRANCH = EXC_SUPPORT;
  localparam bit HAS_DATA = (LINK_COUNT > 0) && LINK_EXC_OPT;

  logic [4:0] cause_reg;
  logic [6:0] detail_reg;
  logic delay_slot_reg;
  logic active_reg;
  logic [4:0] float_reg;
  logic [4:0] float_next;
  logic [31:0] read_data_reg;
  logic read_valid_reg;
  logic [6:0] detail_next;
  logic [31:0] branch_target_reg;
  logic [31:0] exception_data_reg;

  esc_pkg::esc_cause_t cause_in;
  assign cause_in = esc_pkg::esc_cause_t'(EXC_CAUSE);

  // Detail is derived from the incoming cause, not the stored one, so all
  // three fields land on the same edge
  esc_detail_enc u_detail (
    .cause(cause_in),
    .word_access(EXC_WORD_ACCESS),
    .store_access(EXC_STORE_ACCESS),
    .zone_protect(EXC_ZONE_PROTECT),
    .link_index(EXC_LINK_INDEX),
    .detail(detail_next)
  );

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cause_reg <= esc_pkg::CAUSE_RESET;
      detail_reg <= esc_pkg::DET_RESET;
      delay_slot_reg <= 1'b0;
    end else if (EXC_ENTER) begin
      cause_reg <= EXC_CAUSE;
      detail_reg <= detail_next;
      delay_slot_reg <= EXC_DELAY_SLOT;
    end
  end

  // Entry wins over return in the same cycle so a new exception is not lost
  wire active_next = EXC_ENTER | (active_reg & ~EXC_RETURN);
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end

  // Branch captures stop while a handler runs, keeping the return target
  wire branch_load = HAS_BRANCH && BRANCH_IN_DELAY_SLOT && !active_reg;
  esc_capture #(.WIDTH(32), .RESET_VAL(esc_pkg::WORD_RESET)) u_branch (
    .clk(SYS_CLK),
    .rst(RST),
    .load(branch_load),
    .d(BRANCH_TARGET),
    .q(branch_target_reg)
  );

  wire data_load = HAS_DATA && EXC_ENTER && (cause_in == esc_pkg::CAUSE_LINK);
  esc_capture #(.WIDTH(32), .RESET_VAL(esc_pkg::WORD_RESET)) u_data (
    .clk(SYS_CLK),
    .rst(RST),
    .load(data_load),
    .d(EXC_LINK_DATA),
    .q(exception_data_reg)
  );

  // Software write and hardware flag set may collide; the set is ORed in last
  wire float_write = MOVE_TO_SPECIAL && (SPECIAL_REG_SELECTOR == esc_pkg::SEL_FLOAT);
  wire [4:0] float_base = float_write ? SPECIAL_WRITE_DATA[esc_pkg::FLT_W-1:0] : float_reg;
  assign float_next = float_base | FLOAT_FLAG_SET;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      float_reg <= esc_pkg::FLT_RESET;
    end else begin
      float_reg <= float_next;
    end
  end

  // Reserved upper bits are constant zero, so no write can reach them
  wire [31:0] status_word = {19'h00000, delay_slot_reg, detail_reg, cause_reg};
  wire [31:0] float_word = {27'h0000000, float_reg};

  wire sel_status = (SPECIAL_REG_SELECTOR == esc_pkg::SEL_STATUS);
  wire sel_float = (SPECIAL_REG_SELECTOR == esc_pkg::SEL_FLOAT);
  wire sel_branch = HAS_BRANCH && (SPECIAL_REG_SELECTOR == esc_pkg::SEL_BRANCH);
  wire sel_data = HAS_DATA && (SPECIAL_REG_SELECTOR == esc_pkg::SEL_DATA);
  // Absent registers and foreign selectors read as zero
  wire [31:0] read_mux = sel_status ? status_word :
                         sel_float ? float_word :
                         sel_branch ? branch_target_reg :
                         sel_data ? exception_data_reg :
                         esc_pkg::UNMAPPED_READ;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      read_data_reg <= esc_pkg::WORD_RESET;
      read_valid_reg <= 1'b0;
    end else begin
      read_valid_reg <= MOVE_FROM_SPECIAL;
      if (MOVE_FROM_SPECIAL) begin
        read_data_reg <= read_mux;
      end
    end
  end

  assign SPECIAL_READ_DATA = read_data_reg;
  assign SPECIAL_READ_VALID = read_valid_reg;
  assign EXCEPTION_ACTIVE = active_reg;
  assign DELAY_SLOT_FLAG = delay_slot_reg;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  property p_status_read;
    MOVE_FROM_SPECIAL && sel_status && !EXC_ENTER
      |=> SPECIAL_READ_VALID && (SPECIAL_READ_DATA == $past(status_word));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_delay_flag;
    EXC_ENTER |=> DELAY_SLOT_FLAG == $past(EXC_DELAY_SLOT);
  endproperty
  a_delay_flag: assert property (p_delay_flag) else $error("delay flag wrong");

  property p_cause_update;
    EXC_ENTER |=> cause_reg == $past(EXC_CAUSE) && detail_reg == $past(detail_next);
  endproperty
  a_cause_update: assert property (p_cause_update) else $error("cause update");

  property p_unal_word;
    EXC_ENTER && cause_in == esc_pkg::CAUSE_UNALIGNED
      |=> detail_reg[esc_pkg::DET_TOP_BIT] == $past(EXC_WORD_ACCESS);
  endproperty
  a_unal_word: assert property (p_unal_word) else $error("word bit wrong");

  property p_unal_store;
    EXC_ENTER && cause_in == esc_pkg::CAUSE_UNALIGNED
      |=> detail_reg[esc_pkg::DET_STORE_BIT] == $past(EXC_STORE_ACCESS);
  endproperty
  a_unal_store: assert property (p_unal_store) else $error("store bit wrong");

  property p_link_detail;
    EXC_ENTER && cause_in == esc_pkg::CAUSE_LINK
      |=> detail_reg == {3'h0, $past(EXC_LINK_INDEX)};
  endproperty
  a_link_detail: assert property (p_link_detail) else $error("link detail");

  property p_dtlb_detail;
    EXC_ENTER && cause_in == esc_pkg::CAUSE_DTLB
      |=> detail_reg == {1'b0, $past(EXC_STORE_ACCESS), 5'h00};
  endproperty
  a_dtlb_detail: assert property (p_dtlb_detail) else $error("tlb detail");

  property p_zero_detail;
    EXC_ENTER && (cause_in == esc_pkg::CAUSE_ILLEGAL || cause_in == esc_pkg::CAUSE_ITLB
      || cause_in == esc_pkg::CAUSE_DIV_ZERO || cause_in == esc_pkg::CAUSE_FLOAT
      || cause_in == esc_pkg::CAUSE_IBUS || cause_in == esc_pkg::CAUSE_DBUS
      || cause_in == esc_pkg::CAUSE_PRIV)
      |=> detail_reg == esc_pkg::DET_RESET;
  endproperty
  a_zero_detail: assert property (p_zero_detail) else $error("detail not zero");

  property p_branch_hold;
    active_reg |=> $stable(branch_target_reg);
  endproperty
  a_branch_hold: assert property (p_branch_hold) else $error("target moved");

  property p_float_sticky;
    FLOAT_FLAG_SET[esc_pkg::FLT_OVERFLOW] |=> float_reg[esc_pkg::FLT_OVERFLOW];
  endproperty
  a_float_sticky: assert property (p_float_sticky) else $error("flag lost");

  property p_data_capture;
    data_load |=> exception_data_reg == $past(EXC_LINK_DATA);
  endproperty
  a_data_capture: assert property (p_data_capture) else $error("data capture");

  property p_active;
    EXC_ENTER |=> EXCEPTION_ACTIVE [*1] ##1 (EXCEPTION_ACTIVE || $past(EXC_RETURN));
  endproperty
  a_active: assert property (p_active) else $error("active flag wrong");

  property p_dsto_zone;
    EXC_ENTER && cause_in == esc_pkg::CAUSE_DSTORAGE
      |=> detail_reg[esc_pkg::DET_TOP_BIT] == $past(EXC_ZONE_PROTECT);
  endproperty
  a_dsto_zone: assert property (p_dsto_zone) else $error("zone bit wrong");

  property p_dsto_store;
    EXC_ENTER && cause_in == esc_pkg::CAUSE_DSTORAGE
      |=> detail_reg[esc_pkg::DET_STORE_BIT] == $past(EXC_STORE_ACCESS)
        && detail_reg[esc_pkg::DET_STORE_BIT-1:0] == 5'h00;
  endproperty
  a_dsto_store: assert property (p_dsto_store) else $error("storage detail");

  property p_isto_detail;
    EXC_ENTER && cause_in == esc_pkg::CAUSE_ISTORAGE
      |=> detail_reg == {$past(EXC_ZONE_PROTECT), 6'h00};
  endproperty
  a_isto_detail: assert property (p_isto_detail) else $error("istorage detail");

  property p_read_valid;
    1'b1 |=> SPECIAL_READ_VALID == $past(MOVE_FROM_SPECIAL);
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read valid wrong");

  property p_status_reserved;
    MOVE_FROM_SPECIAL && sel_status
      |=> SPECIAL_READ_DATA[31:esc_pkg::STAT_DS_POS+1] == 19'h00000;
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("reserved set");

  property p_float_write;
    float_write && FLOAT_FLAG_SET == 5'h00
      |=> float_reg == $past(SPECIAL_WRITE_DATA[esc_pkg::FLT_W-1:0]);
  endproperty
  a_float_write: assert property (p_float_write) else $error("float write");

  property p_float_read;
    MOVE_FROM_SPECIAL && sel_float
      |=> SPECIAL_READ_DATA == {27'h0000000, $past(float_reg)};
  endproperty
  a_float_read: assert property (p_float_read) else $error("float read");

  property p_branch_load;
    HAS_BRANCH && BRANCH_IN_DELAY_SLOT && !EXCEPTION_ACTIVE
      |=> branch_target_reg == $past(BRANCH_TARGET);
  endproperty
  a_branch_load: assert property (p_branch_load) else $error("target not taken");

  property p_branch_read;
    MOVE_FROM_SPECIAL && sel_branch |=> SPECIAL_READ_DATA == $past(branch_target_reg);
  endproperty
  a_branch_read: assert property (p_branch_read) else $error("target read");

  property p_data_read;
    MOVE_FROM_SPECIAL && sel_data |=> SPECIAL_READ_DATA == $past(exception_data_reg);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read");

  property p_unmapped_read;
    MOVE_FROM_SPECIAL && !(sel_status || sel_float || sel_branch || sel_data)
      |=> SPECIAL_READ_DATA == esc_pkg::UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

  property p_active_clear;
    EXC_RETURN && !EXC_ENTER |=> !EXCEPTION_ACTIVE;
  endproperty
  a_active_clear: assert property (p_active_clear) else $error("active not cleared");

  c_delay_exc: cover property (EXC_ENTER && EXC_DELAY_SLOT ##1 EXCEPTION_ACTIVE);
  c_float_collide: cover property (float_write && |FLOAT_FLAG_SET);
  c_link_exc: cover property (data_load ##[1:4] MOVE_FROM_SPECIAL && sel_data);
  c_return: cover property (EXCEPTION_ACTIVE ##1 !EXCEPTION_ACTIVE);
endmodule

// ---- testbench/exception_status_capture_test.sv ----
// Self-checking bench for the exception status capture block.
// Assumes selector reads answer one cycle after the strobe; inputs move on falling edges.
`timescale 1ns/1ps
module exception_status_capture_test;
  logic sys_clk, rst, move_from_special, move_to_special, enter, ds, wacc, sacc, zone, ret, br;
  logic rvalid, active, dsflag;
  logic [13:0] sel;
  logic [31:0] wdata, rdata, ldata, btgt;
  logic [4:0] cause, fset;
  logic [3:0] lidx;
  logic [4:0] causes [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h10, 5'h11, 5'h12, 5'h13};
  logic [2:0] quals [3] = '{3'b111, 3'b010, 3'b101};
  int n_errors = 0;
  int total_checks = 0;

  esc_top DUT (.SYS_CLK(sys_clk), .RST(rst), .MOVE_FROM_SPECIAL(move_from_special),
    .MOVE_TO_SPECIAL(move_to_special), .SPECIAL_REG_SELECTOR(sel), .SPECIAL_WRITE_DATA(wdata),
    .SPECIAL_READ_DATA(rdata), .SPECIAL_READ_VALID(rvalid), .EXC_ENTER(enter),
    .EXC_CAUSE(cause), .EXC_DELAY_SLOT(ds), .EXC_WORD_ACCESS(wacc),
    .EXC_STORE_ACCESS(sacc), .EXC_ZONE_PROTECT(zone), .EXC_LINK_INDEX(lidx),
    .EXC_LINK_DATA(ldata), .EXC_RETURN(ret), .BRANCH_IN_DELAY_SLOT(br),
    .BRANCH_TARGET(btgt), .FLOAT_FLAG_SET(fset), .EXCEPTION_ACTIVE(active),
    .DELAY_SLOT_FLAG(dsflag));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Mismatches %0d, comparisons %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Qualifiers are set together with causes that must ignore them, so gating shows
  function automatic logic [31:0] status(input logic [4:0] c, input logic [2:0] q,
    input logic [3:0] l, input logic d);
    logic [6:0] t;
    t = 7'h00;
    case (c)
      5'h00: t[3:0] = l;
      5'h01: t[6:5] = q[2:1];
      5'h10: t[6:5] = {q[0], q[1]};
      5'h11: t[6] = q[0];
      5'h12: t[5] = q[1];
      default: t = 7'h00;
    endcase
    return {19'h0, d, t, c};
  endfunction

  task automatic rd(input logic [13:0] s, input logic [31:0] exp);
    @(negedge sys_clk);
    move_from_special = 1'b1;
    sel = s;
    @(negedge sys_clk);
    move_from_special = 1'b0;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, exp);
    @(negedge sys_clk);
    check({31'h0, rvalid}, 32'h0);
  endtask

  task automatic wr(input logic [13:0] s, input logic [31:0] d, input logic [4:0] f);
    @(negedge sys_clk);
    move_to_special = 1'b1;
    sel = s;
    wdata = d;
    fset = f;
    @(negedge sys_clk);
    move_to_special = 1'b0;
    fset = 5'h00;
  endtask

  task automatic exc(input logic [4:0] c, input logic [2:0] q, input logic [3:0] l,
    input logic d);
    @(negedge sys_clk);
    enter = 1'b1;
    cause = c;
    {wacc, sacc, zone} = q;
    lidx = l;
    ds = d;
    @(negedge sys_clk);
    enter = 1'b0;
    check({31'h0, active}, 32'h1);
    check({31'h0, dsflag}, {31'h0, d});
  endtask

  task automatic pulse(input logic is_ret, input logic [31:0] t);
    @(negedge sys_clk);
    ret = is_ret;
    br = ~is_ret;
    btgt = t;
    @(negedge sys_clk);
    ret = 1'b0;
    br = 1'b0;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Whole run is well under 2000 cycles; this limit allows five times that
  initial begin
    #200000;
    n_errors++;
    results();
  end

  initial begin
    {rst, move_from_special, move_to_special, enter, ds, wacc, sacc, zone, ret, br} = 10'h200;
    {sel, wdata, ldata, btgt, cause, fset, lidx} = '0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    rd(14'h0005, 32'h0);
    rd(14'h0007, 32'h0);
    rd(14'h000B, 32'h0);
    rd(14'h000D, 32'h0);
    rd(14'h0003, 32'h0);
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 12; i++) begin
        exc(causes[i], quals[k], 4'h3 << k, i[0] ^ k[0]);
        rd(14'h0005, status(causes[i], quals[k], 4'h3 << k, i[0] ^ k[0]));
      end
    end
    wr(14'h0005, 32'hFFFF_FFFF, 5'h00);
    rd(14'h0005, status(5'h13, 3'b101, 4'hC, 1'b1));
    ldata = 32'hA5C3_1E7F;
    exc(5'h00, 3'b111, 4'hF, 1'b1);
    rd(14'h000D, 32'hA5C3_1E7F);
    rd(14'h0005, 32'h0000_11E0);
    pulse(1'b1, 32'h0);
    check({31'h0, active}, 32'h0);
    pulse(1'b0, 32'h0000_1234);
    rd(14'h000B, 32'h0000_1234);
    exc(5'h02, 3'b000, 4'h0, 1'b1);
    pulse(1'b0, 32'h0000_5678);
    rd(14'h000B, 32'h0000_1234);
    wr(14'h0007, 32'hFFFF_FFFF, 5'h00);
    rd(14'h0007, 32'h0000_001F);
    wr(14'h0007, 32'h0, 5'h00);
    rd(14'h0007, 32'h0);
    wr(14'h0000, 32'hFFFF_FFFF, 5'h04);
    rd(14'h0007, 32'h0000_0004);
    wr(14'h0000, 32'h0, 5'h10);
    rd(14'h0007, 32'h0000_0014);
    wr(14'h0007, 32'h0000_0001, 5'h02);
    rd(14'h0007, 32'h0000_0003);
    // Second reset in mid-run must clear active, delay slot, status, link data and branch target again
    @(negedge sys_clk);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    check({30'h0, active, dsflag}, 32'h0);
    rd(14'h0005, 32'h0);
    rd(14'h000D, 32'h0);
    rd(14'h000B, 32'h0);
    results();
  end
endmodule
